// file: rtl/pmbus_fault_limit_registers.sv
`timescale 1ns/1ps

// What this block does
// - offset corrects current readback and overcurrent compare
// - offset step 1/16 A, span -4..+3.9375 A
// - out-of-range offsets wrap; fixed bits not stored
// - offset exponent fixed -4; top mantissa bits mirror sign
// - only sign and low six bits writable
// - store-all command copies offset to nonvolatile
// - page 0, 1 or 81 routes channel access
// - follower channel stores limit and delay, ignores them
// - master overcurrent gives hiccup or nothing, per setting
// - overcurrent sets byte, word, current flags, alert
// - overcurrent limit exponent -4, reset 0xE120
// - over-temperature fault sets flags and alert
// - fault threshold 1 C steps, 125..160, reset 0x0091
// - over-temperature warning sets flags and alert
// - warning threshold 1 C steps, 100..130, reset 0x006E
// - input overvoltage sets catch-all, input flags, alert
// - overvoltage limit exponent -5, 128..640, reset 0xDA40
// - input low warning sets catch-all, input flags, alert
// - low warning active on follower; 96..384, 0xD860
// - turn-on delay from start to rise, code 3:0
// - delay codes 0.1..100 ms; bits 15:4 zero
module pmbus_fault_limit_registers
   import pmbus_limits_pkg::*;
#(
   parameter int NUM_CH    = 2,
   parameter int STEP_CYC  = TON_STEP_CYC
) (
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire logic                      cmd_valid,
   input  wire logic                      cmd_write,
   input  wire logic [7:0]                cmd_code,
   input  wire logic [15:0]               cmd_wdata,
   input  wire logic [NUM_CH-1:0]         follower,
   input  wire logic [NUM_CH-1:0]         protection_threshold_setting,
   input  wire logic [NUM_CH-1:0][15:0]   iout_sense,
   input  wire logic [NUM_CH-1:0][10:0]   temp_sense,
   input  wire logic [NUM_CH-1:0][10:0]   vin_sense,
   input  wire logic [NUM_CH-1:0]         start_cond,
   output logic      [15:0]               rdata_r,
   output logic                           rvalid_r,
   output logic                           alert_r,
   output logic      [NUM_CH-1:0]         hiccup_r,
   output logic      [NUM_CH-1:0]         rise_r,
   output logic      [NUM_CH-1:0][15:0]   iout_read_r,
   output logic      [NUM_CH-1:0][15:0]   nv_offset_r
);

   localparam int STEP_W = $clog2(STEP_CYC + 1);

   initial begin
      if (NUM_CH != 2) $error("page decode serves exactly two channels");
      if (STEP_CYC < 1) $error("turn-on step must be at least one cycle");
   end

   logic [7:0]          page_r;
   logic                wr_cmd;
   logic                rd_cmd;
   logic                clear_faults;
   logic                store_all;
   logic [NUM_CH-1:0]   wr_ch;
   logic [NUM_CH-1:0]   flag_any;
   logic [15:0]         rword [NUM_CH];
   logic                rd_idx;
   logic [1:0]          sense_live_r;

   assign wr_cmd       = cmd_valid & cmd_write;
   assign rd_cmd       = cmd_valid & ~cmd_write;
   assign clear_faults = wr_cmd & (cmd_code == CMD_CLEAR_FAULTS);
   assign store_all    = wr_cmd & (cmd_code == CMD_STORE_ALL);
   // a both-channels page reads back channel zero
   assign rd_idx       = (page_r == PAGE_CH1);

   // other page values are ignored, keeping the previous selection
   always_ff @(posedge clk) begin
      if (reset) begin
         page_r <= PAGE_CH0;
      end else if (wr_cmd && cmd_code == CMD_PAGE) begin
         if (cmd_wdata[7:0] == PAGE_CH0 || cmd_wdata[7:0] == PAGE_CH1 || cmd_wdata[7:0] == PAGE_BOTH) begin
            page_r <= cmd_wdata[7:0];
         end
      end
   end

   assign wr_ch[0] = wr_cmd & (page_r == PAGE_CH0 || page_r == PAGE_BOTH);
   assign wr_ch[1] = wr_cmd & (page_r == PAGE_CH1 || page_r == PAGE_BOTH);

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r  <= 16'h0000;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= rd_cmd;
         if (rd_cmd) begin
            rdata_r <= (cmd_code == CMD_PAGE) ? {8'h00, page_r} : rword[rd_idx];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         alert_r <= 1'b0;
      end else begin
         alert_r <= |flag_any;
      end
   end

   // synchronisers hold zero for two edges after reset; a zero input voltage
   // would look like an undervoltage warning and raise a false alert, so the
   // low-side compare waits until real samples have arrived
   always_ff @(posedge clk) begin
      if (reset) begin
         sense_live_r <= 2'b00;
      end else begin
         sense_live_r <= {sense_live_r[0], 1'b1};
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         // measurements come from the converter side; two flops each. the
         // values move slowly, so a word may mix two samples for one cycle
         logic [15:0]            iout_s1, iout_s2;
         logic [10:0]            temp_s1, temp_s2;
         logic [10:0]            vin_s1, vin_s2;
         logic                   start_s1, start_s2, start_d;
         logic                   cal_sign_r;
         logic [CAL_LOW_W-1:0]   cal_low_r;
         logic [MANT_W-1:0]      oc_mant_r;
         logic [OT_MANT_W-1:0]   otf_r, otw_r;
         logic [MANT_W-1:0]      vov_r, vuv_r;
         logic [TON_W-1:0]       ton_r;
         logic                   oc_f_r, otf_f_r, otw_f_r, vov_f_r, vuv_f_r;
         logic [15:0]            cal_word;
         logic signed [16:0]     iout_corr;
         logic                   oc_hit, otf_hit, otw_hit, vov_hit, vuv_hit;
         logic [7:0]             sbyte;
         ton_state_t             ton_state_r;
         logic [STEP_W-1:0]      pre_r;
         logic [TON_CNT_W-1:0]   steps_r;
         logic                   step_done;
         logic [MANT_W-1:0]      wmant;

         always_ff @(posedge clk) begin
            if (reset) begin
               iout_s1  <= 16'h0000;
               iout_s2  <= 16'h0000;
               temp_s1  <= 11'h000;
               temp_s2  <= 11'h000;
               vin_s1   <= 11'h000;
               vin_s2   <= 11'h000;
               start_s1 <= 1'b0;
               start_s2 <= 1'b0;
               start_d  <= 1'b0;
            end else begin
               iout_s1  <= iout_sense[ch];
               iout_s2  <= iout_s1;
               temp_s1  <= temp_sense[ch];
               temp_s2  <= temp_s1;
               vin_s1   <= vin_sense[ch];
               vin_s2   <= vin_s1;
               start_s1 <= start_cond[ch];
               start_s2 <= start_s1;
               start_d  <= start_s2;
            end
         end

         assign wmant = cmd_wdata[MANT_W-1:0];

         // out-of-span threshold writes leave the stored limit unchanged
         always_ff @(posedge clk) begin
            if (reset) begin
               cal_sign_r <= RST_CAL_OFFSET[MANT_W-1];
               cal_low_r  <= RST_CAL_OFFSET[CAL_LOW_W-1:0];
               oc_mant_r  <= RST_OC_LIMIT[MANT_W-1:0];
               otf_r      <= RST_OT_FAULT[OT_MANT_W-1:0];
               otw_r      <= RST_OT_WARN[OT_MANT_W-1:0];
               vov_r      <= RST_VIN_OV[MANT_W-1:0];
               vuv_r      <= RST_VIN_UV[MANT_W-1:0];
               ton_r      <= RST_TON[TON_W-1:0];
            end else if (wr_ch[ch]) begin
               case (cmd_code)
                  CMD_CAL_OFFSET: begin
                     cal_sign_r <= cmd_wdata[MANT_W-1];
                     cal_low_r  <= cmd_wdata[CAL_LOW_W-1:0];
                  end
                  CMD_OC_LIMIT: begin
                     oc_mant_r <= wmant;
                  end
                  CMD_OT_FAULT: begin
                     if (wmant >= OT_FAULT_MIN && wmant <= OT_FAULT_MAX) otf_r <= wmant[OT_MANT_W-1:0];
                  end
                  CMD_OT_WARN: begin
                     if (wmant >= OT_WARN_MIN && wmant <= OT_WARN_MAX) otw_r <= wmant[OT_MANT_W-1:0];
                  end
                  CMD_VIN_OV: begin
                     if (wmant >= VIN_OV_MIN && wmant <= VIN_OV_MAX) vov_r <= wmant;
                  end
                  CMD_VIN_UV: begin
                     if (wmant >= VIN_UV_MIN && wmant <= VIN_UV_MAX) vuv_r <= wmant;
                  end
                  CMD_TON_DELAY: begin
                     ton_r <= cmd_wdata[TON_W-1:0];
                  end
                  default: begin
                  end
               endcase
            end
         end

         always_ff @(posedge clk) begin
            if (reset) begin
               nv_offset_r[ch] <= RST_CAL_OFFSET;
            end else if (store_all) begin
               nv_offset_r[ch] <= cal_word;
            end
         end

         assign cal_word = {EXP_AMP, cal_sign_r, {CAL_EXT_W{cal_sign_r}}, cal_low_r};

         // every exponent is fixed at the sense LSB, so mantissas compare
         // directly against the sensed counts with no shift
         assign iout_corr = $signed({iout_s2[15], iout_s2})
                          + $signed({{(17-MANT_W){cal_sign_r}}, cal_word[MANT_W-1:0]});
         assign oc_hit  = ~follower[ch] & (iout_corr > $signed({6'h00, oc_mant_r}));
         assign otf_hit = temp_s2 > {3'h0, otf_r};
         assign otw_hit = temp_s2 > {3'h0, otw_r};
         assign vov_hit = vin_s2 > vov_r;
         assign vuv_hit = sense_live_r[1] & (vin_s2 < vuv_r);

         // a hit in the clearing cycle keeps its flag
         always_ff @(posedge clk) begin
            if (reset) begin
               oc_f_r  <= 1'b0;
               otf_f_r <= 1'b0;
               otw_f_r <= 1'b0;
               vov_f_r <= 1'b0;
               vuv_f_r <= 1'b0;
            end else begin
               oc_f_r  <= oc_hit | (oc_f_r & ~clear_faults);
               otf_f_r <= otf_hit | (otf_f_r & ~clear_faults);
               otw_f_r <= otw_hit | (otw_f_r & ~clear_faults);
               vov_f_r <= vov_hit | (vov_f_r & ~clear_faults);
               vuv_f_r <= vuv_hit | (vuv_f_r & ~clear_faults);
            end
         end

         assign flag_any[ch] = oc_f_r | otf_f_r | otw_f_r | vov_f_r | vuv_f_r;

         always_ff @(posedge clk) begin
            if (reset) begin
               hiccup_r[ch]    <= 1'b0;
               iout_read_r[ch] <= 16'h0000;
            end else begin
               hiccup_r[ch]    <= oc_hit & protection_threshold_setting[ch];
               iout_read_r[ch] <= iout_corr[15:0];
            end
         end

         always_comb begin
            sbyte = 8'h00;
            sbyte[SB_IOUT_OC] = oc_f_r;
            sbyte[SB_TEMP]    = otf_f_r | otw_f_r;
            sbyte[SB_NOTA]    = vov_f_r | vuv_f_r;
         end

         always_comb begin
            rword[ch] = 16'h0000;
            case (cmd_code)
               CMD_CAL_OFFSET:   rword[ch] = cal_word;
               CMD_OC_LIMIT:     rword[ch] = {EXP_AMP, oc_mant_r};
               CMD_OT_FAULT:     rword[ch] = {EXP_DEG, 3'h0, otf_r};
               CMD_OT_WARN:      rword[ch] = {EXP_DEG, 3'h0, otw_r};
               CMD_VIN_OV:       rword[ch] = {EXP_VIN, vov_r};
               CMD_VIN_UV:       rword[ch] = {EXP_VIN, vuv_r};
               CMD_TON_DELAY:    rword[ch] = {12'h000, ton_r};
               CMD_STATUS_BYTE:  rword[ch] = {8'h00, sbyte};
               CMD_STATUS_WORD: begin
                  rword[ch] = {8'h00, sbyte};
                  rword[ch][SW_IOUT]  = oc_f_r;
                  rword[ch][SW_INPUT] = vov_f_r | vuv_f_r;
               end
               CMD_STATUS_IOUT:  rword[ch][SIO_OC_FAULT] = oc_f_r;
               CMD_STATUS_TEMP: begin
                  rword[ch][ST_OT_FAULT] = otf_f_r;
                  rword[ch][ST_OT_WARN]  = otw_f_r;
               end
               CMD_STATUS_INPUT: begin
                  rword[ch][SIN_OV_FAULT] = vov_f_r;
                  rword[ch][SIN_UV_WARN]  = vuv_f_r;
               end
               default:          rword[ch] = 16'h0000;
            endcase
         end

         assign step_done = (pre_r == STEP_W'(STEP_CYC - 1));

         // follower rises with its master, so the stored delay is not applied
         always_ff @(posedge clk) begin
            if (reset) begin
               ton_state_r <= TON_IDLE;
               pre_r       <= '0;
               steps_r     <= '0;
            end else begin
               case (ton_state_r)
                  TON_IDLE: begin
                     pre_r <= '0;
                     if (start_s2 && !start_d) begin
                        steps_r     <= ton_steps(ton_r);
                        ton_state_r <= follower[ch] ? TON_RISE : TON_WAIT;
                     end
                  end
                  TON_WAIT: begin
                     if (!start_s2) begin
                        ton_state_r <= TON_IDLE;
                     end else if (step_done) begin
                        pre_r   <= '0;
                        steps_r <= steps_r - 10'h001;
                        if (steps_r == 10'h001) ton_state_r <= TON_RISE;
                     end else begin
                        pre_r <= pre_r + 1'b1;
                     end
                  end
                  TON_RISE: begin
                     if (!start_s2) ton_state_r <= TON_IDLE;
                  end
                  default: ton_state_r <= TON_IDLE;
               endcase
            end
         end

         always_ff @(posedge clk) begin
            if (reset) begin
               rise_r[ch] <= 1'b0;
            end else begin
               rise_r[ch] <= (ton_state_r == TON_RISE);
            end
         end
      end
   endgenerate

endmodule

// file: rtl/pmbus_limits_pkg.sv
package pmbus_limits_pkg;

   // command codes
   localparam logic [7:0] CMD_PAGE         = 8'h00;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_STORE_ALL    = 8'h11;
   localparam logic [7:0] CMD_CAL_OFFSET   = 8'h39;
   localparam logic [7:0] CMD_OC_LIMIT     = 8'h46;
   localparam logic [7:0] CMD_OT_FAULT     = 8'h4F;
   localparam logic [7:0] CMD_OT_WARN      = 8'h51;
   localparam logic [7:0] CMD_VIN_OV       = 8'h55;
   localparam logic [7:0] CMD_VIN_UV       = 8'h58;
   localparam logic [7:0] CMD_TON_DELAY    = 8'h60;
   localparam logic [7:0] CMD_STATUS_BYTE  = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
   localparam logic [7:0] CMD_STATUS_IOUT  = 8'h7B;
   localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;
   localparam logic [7:0] CMD_STATUS_TEMP  = 8'h7D;

   // page selections
   localparam logic [7:0] PAGE_CH0  = 8'h00;
   localparam logic [7:0] PAGE_CH1  = 8'h01;
   localparam logic [7:0] PAGE_BOTH = 8'h81;

   // linear word layout: exponent [15:11], mantissa [10:0]
   localparam int         MANT_W    = 11;
   localparam int         EXP_W     = 5;
   localparam int         CAL_LOW_W = 6;
   localparam int         CAL_EXT_W = 4;
   localparam int         OT_MANT_W = 8;
   localparam int         TON_W     = 4;
   localparam logic [4:0] EXP_AMP   = 5'h1C;
   localparam logic [4:0] EXP_VIN   = 5'h1B;
   localparam logic [4:0] EXP_DEG   = 5'h00;

   // reset values
   localparam logic [15:0] RST_CAL_OFFSET = 16'hE000;
   localparam logic [15:0] RST_OC_LIMIT   = 16'hE120;
   localparam logic [15:0] RST_OT_FAULT   = 16'h0091;
   localparam logic [15:0] RST_OT_WARN    = 16'h006E;
   localparam logic [15:0] RST_VIN_OV     = 16'hDA40;
   localparam logic [15:0] RST_VIN_UV     = 16'hD860;
   localparam logic [15:0] RST_TON        = 16'h0000;

   // accepted mantissa spans
   localparam logic [10:0] OT_FAULT_MIN = 11'h07D;
   localparam logic [10:0] OT_FAULT_MAX = 11'h0A0;
   localparam logic [10:0] OT_WARN_MIN  = 11'h064;
   localparam logic [10:0] OT_WARN_MAX  = 11'h082;
   localparam logic [10:0] VIN_OV_MIN   = 11'h080;
   localparam logic [10:0] VIN_OV_MAX   = 11'h280;
   localparam logic [10:0] VIN_UV_MIN   = 11'h060;
   localparam logic [10:0] VIN_UV_MAX   = 11'h180;

   // status bit positions
   localparam int SB_IOUT_OC   = 4;
   localparam int SB_TEMP      = 2;
   localparam int SB_NOTA      = 0;
   localparam int SW_IOUT      = 14;
   localparam int SW_INPUT     = 13;
   localparam int SIO_OC_FAULT = 7;
   localparam int ST_OT_FAULT  = 7;
   localparam int ST_OT_WARN   = 6;
   localparam int SIN_OV_FAULT = 7;
   localparam int SIN_UV_WARN  = 5;

   // turn-on delay timebase: table entries are multiples of 0.1 ms
   localparam int CLK_PERIOD_NS = 4;
   localparam int TON_STEP_NS   = 100000;
   localparam int TON_STEP_CYC  = TON_STEP_NS / CLK_PERIOD_NS;
   localparam int TON_CNT_W     = 10;

   typedef enum logic [2:0] {
      TON_IDLE = 3'b001,
      TON_WAIT = 3'b010,
      TON_RISE = 3'b100
   } ton_state_t;

   // delay code to count of 0.1 ms steps
   function automatic logic [TON_CNT_W-1:0] ton_steps(input logic [TON_W-1:0] code);
      logic [TON_CNT_W-1:0] s;
      s = 10'h001;
      case (code)
         4'h0: s = 10'h001;
         4'h1: s = 10'h00A;
         4'h2: s = 10'h014;
         4'h3: s = 10'h01E;
         4'h4: s = 10'h028;
         4'h5: s = 10'h032;
         4'h6: s = 10'h03C;
         4'h7: s = 10'h050;
         4'h8: s = 10'h064;
         4'h9: s = 10'h078;
         4'hA: s = 10'h0C8;
         4'hB: s = 10'h12C;
         4'hC: s = 10'h190;
         4'hD: s = 10'h258;
         4'hE: s = 10'h320;
         4'hF: s = 10'h3E8;
         default: s = 10'h001;
      endcase
      return s;
   endfunction

endpackage

// file: tb/host_model.sv
`timescale 1ns/1ps
module host_model
   import pmbus_limits_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [15:0] rdata_r,
   input  wire logic        rvalid_r,
   output logic             cmd_valid,
   output logic             cmd_write,
   output logic [7:0]       cmd_code,
   output logic [15:0]      cmd_wdata
);
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code  = 8'hFF;
      cmd_wdata = 16'hFFFF;
   end
   task automatic go(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(posedge clk) #1;
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_code  = c;
      cmd_wdata = d;
      @(posedge clk) #1;
      cmd_valid = 1'b0;
      // idle lines show the inverse so nothing can lean on a stale command
      cmd_code  = ~c;
      cmd_wdata = ~d;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      go(1'b1, c, d);
   endtask
   task automatic page(input logic [7:0] p);
      go(1'b1, CMD_PAGE, {8'h00, p});
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      int n;
      go(1'b0, c, 16'h0000);
      n = 0;
      while (rvalid_r !== 1'b1 && n < 4) begin
         @(posedge clk) #1;
         n++;
      end
      d = (rvalid_r === 1'b1) ? rdata_r : 16'hXXXX;
   endtask
endmodule

// file: tb/pmbus_limits_sva.sv
`timescale 1ns/1ps
module pmbus_limits_chk
   import pmbus_limits_pkg::*;
#(
   parameter int NUM_CH = 2
) (
   input wire logic                    clk,
   input wire logic                    reset,
   input wire logic                    cmd_valid,
   input wire logic                    cmd_write,
   input wire logic [7:0]              cmd_code,
   input wire logic [NUM_CH-1:0]       follower,
   input wire logic [NUM_CH-1:0]       protection_threshold_setting,
   input wire logic [NUM_CH-1:0]       start_cond,
   input wire logic [15:0]             rdata_r,
   input wire logic                    rvalid_r,
   input wire logic [NUM_CH-1:0]       hiccup_r,
   input wire logic [NUM_CH-1:0]       rise_r,
   input wire logic [NUM_CH-1:0][15:0] nv_offset_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic rd_q;
   assign rd_q = cmd_valid && !cmd_write;
   a_read_answer: assert property (rd_q |=> rvalid_r) else $error("read not answered");
   a_answer_cause: assert property (rvalid_r |-> $past(rd_q)) else $error("answer without read");
   a_cal_fixed: assert property (rvalid_r && $past(cmd_code) == CMD_CAL_OFFSET |->
      rdata_r[15:11] == EXP_AMP && (rdata_r[10:6] == 5'h00 || rdata_r[10:6] == 5'h1F))
      else $error("offset fixed bits wrong");
   a_oc_exp: assert property (rvalid_r && $past(cmd_code) == CMD_OC_LIMIT |-> rdata_r[15:11] == EXP_AMP)
      else $error("limit exponent wrong");
   a_ot_exp: assert property (rvalid_r && $past(cmd_code) == CMD_OT_FAULT |-> rdata_r[15:8] == 8'h00)
      else $error("temperature exponent wrong");
   a_ov_exp: assert property (rvalid_r && $past(cmd_code) == CMD_VIN_OV |-> rdata_r[15:11] == EXP_VIN)
      else $error("overvoltage exponent wrong");
   a_ton_upper: assert property (rvalid_r && $past(cmd_code) == CMD_TON_DELAY |-> rdata_r[15:4] == 12'h000)
      else $error("delay upper bits set");
   a_hiccup_cause: assert property (hiccup_r[0] |-> $past(protection_threshold_setting[0]) && !$past(follower[0]))
      else $error("hiccup without setting");
   a_nv_hold: assert property (!(cmd_valid && cmd_write && cmd_code == CMD_STORE_ALL) |=> $stable(nv_offset_r))
      else $error("nonvolatile copy changed");
   a_rise_delay: assert property ($rose(rise_r[0]) && !$past(follower[0]) |-> $past(start_cond[0], 4))
      else $error("output rose too early");
   c_read: cover property (rvalid_r);
   c_hiccup: cover property (hiccup_r[0]);
   c_rise: cover property ($rose(rise_r[0]));
endmodule
bind pmbus_fault_limit_registers pmbus_limits_chk #(.NUM_CH(NUM_CH)) chk_i (.clk, .reset, .cmd_valid, .cmd_write,
   .cmd_code, .follower, .protection_threshold_setting, .start_cond, .rdata_r, .rvalid_r, .hiccup_r, .rise_r,
   .nv_offset_r);

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import pmbus_limits_pkg::*;
   logic             clk = 1'b0;
   logic             reset = 1'b1;
   logic             cmd_valid, cmd_write;
   logic [7:0]       cmd_code;
   logic [15:0]      cmd_wdata, rdata_r, d, w;
   logic             rvalid_r, alert_r, ps;
   logic [1:0]       follower = 2'b00, setting = 2'b00, start_cond = 2'b00, hiccup_r, rise_r;
   logic [1:0][15:0] iout_sense = '0, iout_read_r, nv_offset_r;
   logic [1:0][10:0] temp_sense, vin_sense;
   int               n_mismatch = 0, n_tests = 0, cyc = 0, seed = 42372, n, base;
   int               steps[16] = '{1, 10, 20, 30, 40, 50, 60, 80, 100, 120, 200, 300, 400, 600, 800, 1000};
   logic [7:0]       tcode[4] = '{CMD_OT_FAULT, CMD_OT_WARN, CMD_VIN_OV, CMD_VIN_UV};
   logic [15:0]      tmin[4] = '{16'h007D, 16'h0064, 16'hD880, 16'hD860};
   logic [15:0]      tmax[4] = '{16'h00A0, 16'h0082, 16'hDA80, 16'hD980};
   logic [7:0]       rcode[7] = '{CMD_CAL_OFFSET, CMD_OC_LIMIT, CMD_OT_FAULT, CMD_OT_WARN, CMD_VIN_OV, CMD_VIN_UV,
                                  CMD_TON_DELAY};
   logic [15:0]      rval[7] = '{16'hE000, 16'hE120, 16'h0091, 16'h006E, 16'hDA40, 16'hD860, 16'h0000};
   pmbus_fault_limit_registers #(.NUM_CH(2), .STEP_CYC(4)) DUT (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .follower(follower),
      .protection_threshold_setting(setting), .iout_sense(iout_sense), .temp_sense(temp_sense),
      .vin_sense(vin_sense), .start_cond(start_cond), .rdata_r(rdata_r), .rvalid_r(rvalid_r), .alert_r(alert_r),
      .hiccup_r(hiccup_r), .rise_r(rise_r), .iout_read_r(iout_read_r), .nv_offset_r(nv_offset_r));
   host_model host (.clk(clk), .rdata_r(rdata_r), .rvalid_r(rvalid_r), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
   initial begin
      forever #2 clk = ~clk;
   end
   function automatic logic [15:0] cal_exp(input logic [15:0] v);
      return {EXP_AMP, {5{v[10]}}, v[5:0]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic settle(input logic [10:0] t, input logic [10:0] v);
      temp_sense = {2{t}};
      vin_sense  = {2{v}};
      repeat (6) @(posedge clk);
      #1;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         finish_test;
      end
   end
   initial begin
      temp_sense = {2{11'd25}};
      vin_sense  = {2{11'd400}};
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      for (int i = 0; i < 7; i++) begin
         host.rd(rcode[i], d);
         chk(d, rval[i]);
      end
      chk(nv_offset_r[0], 16'hE000);
      for (int i = 0; i < 8; i++) begin
         w = (i == 0) ? 16'hFFFF : $random(seed);
         host.wr(CMD_CAL_OFFSET, w);
         host.rd(CMD_CAL_OFFSET, d);
         chk(d, cal_exp(w));
      end
      host.page(PAGE_CH1);
      host.wr(CMD_OC_LIMIT, 16'h0123);
      host.rd(CMD_OC_LIMIT, d);
      chk(d, 16'hE123);
      host.page(PAGE_CH0);
      host.rd(CMD_OC_LIMIT, d);
      chk(d, 16'hE120);
      host.page(PAGE_BOTH);
      host.wr(CMD_PAGE, 16'h0005);
      host.wr(CMD_OC_LIMIT, 16'hE120);
      host.wr(CMD_CAL_OFFSET, 16'h0010);
      host.page(PAGE_CH1);
      host.rd(CMD_CAL_OFFSET, d);
      chk(d, 16'hE010);
      host.page(PAGE_BOTH);
      for (int i = 0; i < 4; i++) begin
         host.wr(tcode[i], tmin[i]);
         host.wr(tcode[i], tmin[i] - 16'h0001);
         host.rd(tcode[i], d);
         chk(d, tmin[i]);
         host.wr(tcode[i], tmax[i]);
         host.wr(tcode[i], tmax[i] + 16'h0001);
         host.rd(tcode[i], d);
         chk(d, tmax[i]);
      end
      settle(11'd25, 11'd400);
      host.wr(CMD_CLEAR_FAULTS, 16'h0000);
      host.rd(CMD_STATUS_WORD, d);
      chk(d, 16'h0000);
      settle(11'd131, 11'd400);
      host.rd(CMD_STATUS_TEMP, d);
      chk(d, 16'h0040);
      settle(11'd161, 11'd641);
      host.rd(CMD_STATUS_TEMP, d);
      chk(d, 16'h00C0);
      host.rd(CMD_STATUS_INPUT, d);
      chk(d, 16'h0080);
      host.rd(CMD_STATUS_WORD, d);
      chk(d, 16'h2005);
      chk({15'h0, alert_r}, 16'h0001);
      follower = 2'b01;
      settle(11'd25, 11'd383);
      host.wr(CMD_CLEAR_FAULTS, 16'h0000);
      host.rd(CMD_STATUS_INPUT, d);
      chk(d, 16'h0020);
      follower = 2'b00;
      settle(11'd25, 11'd400);
      host.wr(CMD_CLEAR_FAULTS, 16'h0000);
      @(posedge clk) #1;
      chk({15'h0, alert_r}, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         iout_sense = {16'h0000, 16'd270 + 16'(i)};
         ps = $random(seed);
         setting = {1'b0, ps};
         repeat (6) @(posedge clk);
         #1;
         chk(iout_read_r[0], 16'd286 + 16'(i));
         host.rd(CMD_STATUS_IOUT, d);
         chk(d, (i > 2) ? 16'h0080 : 16'h0000);
         chk({15'h0, hiccup_r[0]}, (i > 2) ? {15'h0, ps} : 16'h0000);
      end
      host.rd(CMD_STATUS_WORD, d);
      chk(d, 16'h4010);
      iout_sense = {2{16'hFFF0}};
      repeat (4) @(posedge clk);
      #1;
      chk(iout_read_r[1], 16'h0000);
      // clear only once the old overcurrent sample has left the synchroniser
      host.wr(CMD_CLEAR_FAULTS, 16'h0000);
      follower = 2'b01;
      iout_sense = {16'h0000, 16'd400};
      repeat (6) @(posedge clk);
      host.rd(CMD_STATUS_IOUT, d);
      chk(d, 16'h0000);
      follower = 2'b00;
      iout_sense = '0;
      host.wr(CMD_STORE_ALL, 16'h0000);
      chk(nv_offset_r[0], 16'hE010);
      for (int c = 0; c < 16; c++) begin
         host.wr(CMD_TON_DELAY, {12'hABC, 4'(c)});
         host.rd(CMD_TON_DELAY, d);
         chk(d, {12'h000, 4'(c)});
         start_cond = 2'b01;
         n = 0;
         while (rise_r[0] !== 1'b1 && n < 5000) begin
            @(posedge clk) #1;
            n++;
         end
         if (c == 0)
            base = n;
         chk(16'(n), 16'(base + (steps[c] - 1) * 4));
         start_cond = 2'b00;
         repeat (6) @(posedge clk);
         #1;
      end
      follower = 2'b10;
      start_cond = 2'b10;
      n = 0;
      while (rise_r[1] !== 1'b1 && n < 5000) begin
         @(posedge clk) #1;
         n++;
      end
      chk({15'h0, n < base}, 16'h0001);
      finish_test;
   end
endmodule
